// ===== common/csc_pkg.sv
// Constants and types shared by the codec serial control block
package csc_pkg;

  // ==========================================================================
  // Control word layout
  localparam int WORD_BITS = 16;
  localparam int ADDR_HI = 10;
  localparam int ADDR_LO = 9;
  localparam int COMMIT_BIT = 8;
  localparam int GAIN_MSB = 7;

  // ==========================================================================
  // Register addresses
  localparam logic [1:0] REG_LEFT = 2'h0;
  localparam logic [1:0] REG_RIGHT = 2'h1;
  localparam logic [1:0] REG_CONV = 2'h2;
  localparam logic [1:0] REG_FORMAT = 2'h3;

  // ==========================================================================
  // Converter control fields
  localparam int ADC_SLEEP_BIT = 8;
  localparam int HPF_SKIP_BIT = 7;
  localparam int DAC_SLEEP_BIT = 6;
  localparam int COMMON_GAIN_BIT = 5;
  localparam int ZERO_DET_BIT = 4;
  localparam int MIDSCALE_BIT = 3;
  localparam int DEEMPH_HI = 2;
  localparam int DEEMPH_LO = 1;
  localparam int FADE_BIT = 0;

  // ==========================================================================
  // Format control fields
  localparam int ECHO_BIT = 5;
  localparam int LAYOUT_HI = 3;
  localparam int LAYOUT_LO = 2;
  localparam int POL_BIT = 1;

  // ==========================================================================
  // Reset values and codes
  localparam logic [7:0] GAIN_RST = 8'hff;
  localparam logic [7:0] GAIN_MUTE = 8'h00;
  localparam logic [1:0] DEEMPH_441 = 2'h0;
  localparam logic [1:0] DEEMPH_OFF = 2'h1;
  localparam logic [1:0] DEEMPH_48 = 2'h2;
  localparam logic [1:0] DEEMPH_32 = 2'h3;
  localparam logic [1:0] LAYOUT_RJ16 = 2'h0;
  localparam logic [1:0] LAYOUT_I2S = 2'h3;

  // ==========================================================================
  // Timing counts, in bit-clock cycles
  localparam int ZERO_RUN_LEN = 65536;
  localparam int ZERO_CNT_W = 17;

  typedef enum logic [1:0] {
    DAC_RUN,
    DAC_MIDSCALE,
    DAC_GROUND
  } csc_dac_mode_t;

endpackage : csc_pkg

// ===== common/csc_word_if.sv
// Carrier for received control words between receiver and core
`timescale 1ns/100ps
interface csc_word_if;
  logic valid;
  logic [15:0] word;

  modport rx (
    output valid,
    output word
  );
  modport core (
    input valid,
    input word
  );
endinterface : csc_word_if

// ===== rtl/csc_serial_rx.sv
// Three-wire serial receiver for 16-bit control words
`timescale 1ns/100ps
module csc_serial_rx
  import csc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ctl_shift_clock,
  input wire logic ctl_serial_in,
  input wire logic ctl_latch_strobe,
  csc_word_if.rx out
);

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic clk_q;
  logic strobe_q;
  logic [15:0] shifter;
  logic [15:0] next_shifter;
  logic valid;
  logic next_valid;
  logic [15:0] word;
  logic [15:0] next_word;

  // ==========================================================================
  // Pin synchronisers; only the second stage is read
  always_ff @(posedge core_clk) begin
    sync_a <= {ctl_latch_strobe, ctl_serial_in, ctl_shift_clock};
    sync_b <= sync_a;
  end

  // ==========================================================================
  // Shift and latch
  always_comb begin
    next_shifter = shifter;
    next_valid = 1'b0;
    next_word = word;
    if (sync_b[0] && !clk_q) begin
      next_shifter = {shifter[14:0], sync_b[1]};
    end
    if (sync_b[2] && !strobe_q) begin
      next_valid = 1'b1;
      next_word = shifter;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_q <= 1'b0;
      strobe_q <= 1'b0;
      shifter <= 16'h0000;
      valid <= 1'b0;
      word <= 16'h0000;
    end else begin
      clk_q <= sync_b[0];
      strobe_q <= sync_b[2];
      shifter <= next_shifter;
      valid <= next_valid;
      word <= next_word;
    end
  end

  assign out.valid = valid;
  assign out.word = word;

endmodule : csc_serial_rx

// ===== rtl/csc_zero_run.sv
// Counts consecutive zero data bits, one per rising bit-clock edge
`timescale 1ns/100ps
module csc_zero_run
  import csc_pkg::*;
#(
  parameter int RUN_LEN = ZERO_RUN_LEN
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic bit_tick,
  input wire logic data_bit,
  output logic zero_run
);

  logic [ZERO_CNT_W-1:0] count;
  logic [ZERO_CNT_W-1:0] next_count;
  logic next_zero_run;

  // ==========================================================================
  // Saturating run counter; any one bit restarts it
  always_comb begin
    next_count = count;
    if (bit_tick) begin
      if (data_bit) begin
        next_count = '0;
      end else if (count != ZERO_CNT_W'(RUN_LEN)) begin
        next_count = count + 1'b1;
      end
    end
    next_zero_run = (next_count == ZERO_CNT_W'(RUN_LEN));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= '0;
      zero_run <= 1'b0;
    end else begin
      count <= next_count;
      zero_run <= next_zero_run;
    end
  end

endmodule : csc_zero_run

// ===== rtl/csc_ctrl_top.sv
// Serial control register bank of a stereo audio codec
`timescale 1ns/100ps
module csc_ctrl_top
  import csc_pkg::*;
#(
  parameter int ZERO_RUN_CYCLES = ZERO_RUN_LEN
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ctl_shift_clock,
  input wire logic ctl_serial_in,
  input wire logic ctl_latch_strobe,
  input wire logic bit_clock_in,
  input wire logic word_clock_in,
  input wire logic dac_serial_in,
  input wire logic adc_data_raw,
  output logic adc_serial_out,
  output logic [7:0] left_level,
  output logic [7:0] right_level,
  output logic adc_sleep,
  output logic hpf_skip,
  output logic dac_sleep,
  output logic [1:0] deemph_select,
  output logic [1:0] word_layout_sel,
  output logic adc_to_dac_echo,
  output logic left_phase,
  output csc_pkg::csc_dac_mode_t dac_out_mode,
  output logic amp_disconnect,
  output logic zero_flag_n_o,
  output logic zero_flag_n_oe
);

  import csc_pkg::*;

  csc_word_if wbus ();

  logic [2:0] pin_a;
  logic [2:0] pin_b;
  logic bclk_q;
  logic wclk_q;
  logic bit_tick;
  logic word_tick;
  logic zero_run;

  logic [7:0] left_code;
  logic [7:0] right_code;
  logic [7:0] left_applied;
  logic [7:0] right_applied;
  logic common_gain_sel;
  logic zero_run_detect;
  logic dac_force_midscale;
  logic quiet_fade_ctl;
  logic echo_req;
  logic word_clock_polarity;

  logic [7:0] next_left_code;
  logic [7:0] next_right_code;
  logic [7:0] next_left_applied;
  logic [7:0] next_right_applied;
  logic next_adc_sleep;
  logic next_hpf_skip;
  logic next_dac_sleep;
  logic next_common_gain_sel;
  logic next_zero_run_detect;
  logic next_dac_force_midscale;
  logic [1:0] next_deemph_select;
  logic next_quiet_fade_ctl;
  logic next_echo_req;
  logic [1:0] next_word_layout_sel;
  logic next_word_clock_polarity;

  logic [7:0] next_left_level;
  logic [7:0] next_right_level;
  logic [7:0] left_target;
  logic [7:0] right_target;
  logic next_adc_serial_out;
  logic next_adc_to_dac_echo;
  logic next_left_phase;
  csc_dac_mode_t next_dac_out_mode;
  logic next_amp_disconnect;

  // ==========================================================================
  // Control word receiver
  // serial port only
  csc_serial_rx u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .ctl_shift_clock(ctl_shift_clock),
    .ctl_serial_in(ctl_serial_in),
    .ctl_latch_strobe(ctl_latch_strobe),
    .out(wbus)
  );

  // ==========================================================================
  // Audio clock and data synchronisers
  always_ff @(posedge core_clk) begin
    pin_a <= {dac_serial_in, word_clock_in, bit_clock_in};
    pin_b <= pin_a;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Load the pin level so no false edge follows reset
      bclk_q <= pin_b[0];
      wclk_q <= pin_b[1];
    end else begin
      bclk_q <= pin_b[0];
      wclk_q <= pin_b[1];
    end
  end

  assign bit_tick = pin_b[0] && !bclk_q;
  assign word_tick = pin_b[1] && !wclk_q;

  // ==========================================================================
  // Zero-run detector on the DAC input stream
  // zero run count
  csc_zero_run #(
    .RUN_LEN(ZERO_RUN_CYCLES)
  ) u_zero (
    .core_clk(core_clk),
    .rst(rst),
    .bit_tick(bit_tick),
    .data_bit(pin_b[2]),
    .zero_run(zero_run)
  );

  // ==========================================================================
  // Register writes
  always_comb begin
    next_left_code = left_code;
    next_right_code = right_code;
    next_left_applied = left_applied;
    next_right_applied = right_applied;
    next_adc_sleep = adc_sleep;
    next_hpf_skip = hpf_skip;
    next_dac_sleep = dac_sleep;
    next_common_gain_sel = common_gain_sel;
    next_zero_run_detect = zero_run_detect;
    next_dac_force_midscale = dac_force_midscale;
    next_deemph_select = deemph_select;
    next_quiet_fade_ctl = quiet_fade_ctl;
    next_echo_req = echo_req;
    next_word_layout_sel = word_layout_sel;
    next_word_clock_polarity = word_clock_polarity;
    if (wbus.valid) begin
      unique case (wbus.word[ADDR_HI:ADDR_LO])
        REG_LEFT: begin
          next_left_code = wbus.word[GAIN_MSB:0];
        end
        REG_RIGHT: begin
          next_right_code = wbus.word[GAIN_MSB:0];
        end
        REG_CONV: begin
          next_adc_sleep = wbus.word[ADC_SLEEP_BIT];
          next_hpf_skip = wbus.word[HPF_SKIP_BIT];
          next_dac_sleep = wbus.word[DAC_SLEEP_BIT];
          next_common_gain_sel = wbus.word[COMMON_GAIN_BIT];
          next_zero_run_detect = wbus.word[ZERO_DET_BIT];
          next_dac_force_midscale = wbus.word[MIDSCALE_BIT];
          next_deemph_select = wbus.word[DEEMPH_HI:DEEMPH_LO];
          next_quiet_fade_ctl = wbus.word[FADE_BIT];
        end
        REG_FORMAT: begin
          next_echo_req = wbus.word[ECHO_BIT];
          next_word_layout_sel = wbus.word[LAYOUT_HI:LAYOUT_LO];
          next_word_clock_polarity = wbus.word[POL_BIT];
        end
      endcase
      if (wbus.word[ADDR_HI] == 1'b0 && wbus.word[COMMIT_BIT]) begin
        next_left_applied = next_left_code;
        next_right_applied = next_right_code;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      left_code <= GAIN_RST;
      right_code <= GAIN_RST;
      left_applied <= GAIN_RST;
      right_applied <= GAIN_RST;
      adc_sleep <= 1'b0;
      hpf_skip <= 1'b0;
      dac_sleep <= 1'b0;
      common_gain_sel <= 1'b0;
      zero_run_detect <= 1'b0;
      dac_force_midscale <= 1'b0;
      deemph_select <= DEEMPH_OFF;
      quiet_fade_ctl <= 1'b0;
      echo_req <= 1'b0;
      word_layout_sel <= LAYOUT_RJ16;
      word_clock_polarity <= 1'b0;
    end else begin
      left_code <= next_left_code;
      right_code <= next_right_code;
      left_applied <= next_left_applied;
      right_applied <= next_right_applied;
      adc_sleep <= next_adc_sleep;
      hpf_skip <= next_hpf_skip;
      dac_sleep <= next_dac_sleep;
      common_gain_sel <= next_common_gain_sel;
      zero_run_detect <= next_zero_run_detect;
      dac_force_midscale <= next_dac_force_midscale;
      deemph_select <= next_deemph_select;
      quiet_fade_ctl <= next_quiet_fade_ctl;
      echo_req <= next_echo_req;
      word_layout_sel <= next_word_layout_sel;
      word_clock_polarity <= next_word_clock_polarity;
    end
  end

  // ==========================================================================
  // Level ramp, one code step per sample period
  // Stepping instead of jumping keeps mute and gain changes click-free
  always_comb begin
    left_target = left_applied;
    right_target = common_gain_sel ? left_applied : right_applied;
    if (quiet_fade_ctl) begin
      left_target = GAIN_MUTE;
      right_target = GAIN_MUTE;
    end
    next_left_level = left_level;
    next_right_level = right_level;
    if (word_tick) begin
      if (left_level < left_target) begin
        next_left_level = left_level + 8'h01;
      end else if (left_level > left_target) begin
        next_left_level = left_level - 8'h01;
      end
      if (right_level < right_target) begin
        next_right_level = right_level + 8'h01;
      end else if (right_level > right_target) begin
        next_right_level = right_level - 8'h01;
      end
    end
  end

  // ==========================================================================
  // Converter and format outputs
  always_comb begin
    next_adc_serial_out = adc_sleep ? 1'b0 : adc_data_raw;
    next_adc_to_dac_echo = echo_req && (word_layout_sel != LAYOUT_I2S);
    if (word_layout_sel == LAYOUT_I2S) begin
      next_left_phase = !pin_b[1];
    end else begin
      next_left_phase = pin_b[1] ^ word_clock_polarity;
    end
    next_amp_disconnect = zero_run_detect && zero_run;
    if (dac_sleep) begin
      next_dac_out_mode = DAC_GROUND;
    end else if (dac_force_midscale || next_amp_disconnect) begin
      next_dac_out_mode = DAC_MIDSCALE;
    end else begin
      next_dac_out_mode = DAC_RUN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      left_level <= GAIN_RST;
      right_level <= GAIN_RST;
      adc_serial_out <= 1'b0;
      adc_to_dac_echo <= 1'b0;
      left_phase <= 1'b0;
      amp_disconnect <= 1'b0;
      dac_out_mode <= DAC_RUN;
    end else begin
      left_level <= next_left_level;
      right_level <= next_right_level;
      adc_serial_out <= next_adc_serial_out;
      adc_to_dac_echo <= next_adc_to_dac_echo;
      left_phase <= next_left_phase;
      amp_disconnect <= next_amp_disconnect;
      dac_out_mode <= next_dac_out_mode;
    end
  end

  // Open-drain zero flag pulls low while the run is complete
  assign zero_flag_n_o = 1'b0;
  assign zero_flag_n_oe = zero_run;

endmodule : csc_ctrl_top

// ===== tb/csc_ctrl_top_sva.sv
// Port-level checker for the codec serial control block
`timescale 1ns/100ps
module csc_ctrl_sva #(
  parameter int ZERO_RUN_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ctl_shift_clock,
  input wire logic ctl_serial_in,
  input wire logic ctl_latch_strobe,
  input wire logic bit_clock_in,
  input wire logic word_clock_in,
  input wire logic dac_serial_in,
  input wire logic adc_data_raw,
  input wire logic adc_serial_out,
  input wire logic [7:0] left_level,
  input wire logic [7:0] right_level,
  input wire logic adc_sleep,
  input wire logic hpf_skip,
  input wire logic dac_sleep,
  input wire logic [1:0] deemph_select,
  input wire logic [1:0] word_layout_sel,
  input wire logic adc_to_dac_echo,
  input wire logic left_phase,
  input wire csc_pkg::csc_dac_mode_t dac_out_mode,
  input wire logic amp_disconnect,
  input wire logic zero_flag_n_o,
  input wire logic zero_flag_n_oe
);
  import csc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ========
  // Assertions
  a_quiet_no_update: assert property (
    (!ctl_latch_strobe) [*8] |=> $stable({adc_sleep, hpf_skip, dac_sleep,
      deemph_select, word_layout_sel}))
    else $error("control output moved with no latch");
  a_adc_sleep_zero: assert property (
    adc_sleep && $past(adc_sleep) |-> !adc_serial_out)
    else $error("adc data out not held low in sleep");
  a_adc_follow: assert property (
    !adc_sleep && !$past(adc_sleep) && !$past(rst)
      |-> adc_serial_out == $past(adc_data_raw))
    else $error("adc data out does not follow its source");
  a_ground_prio: assert property (
    dac_sleep && $past(dac_sleep) |-> dac_out_mode == DAC_GROUND)
    else $error("dac sleep did not ground the output");
  a_echo_no_i2s: assert property (
    word_layout_sel == LAYOUT_I2S && $past(word_layout_sel) == LAYOUT_I2S
      |-> !adc_to_dac_echo)
    else $error("echo active in i2s layout");
  a_flag_low: assert property (
    zero_flag_n_oe |-> !zero_flag_n_o)
    else $error("zero flag driven high");
  a_amp_flag: assert property (
    $rose(amp_disconnect) |-> zero_flag_n_oe || $past(zero_flag_n_oe))
    else $error("amp cut without a zero run");
  a_amp_mode: assert property (
    amp_disconnect && $past(amp_disconnect) && !dac_sleep && !$past(dac_sleep)
      |-> dac_out_mode == DAC_MIDSCALE)
    else $error("amp cut but output mode wrong");
  a_level_step: assert property (
    left_level != $past(left_level) |-> (left_level - $past(left_level)
      == 8'h01) || ($past(left_level) - left_level == 8'h01))
    else $error("left level jumped more than one code");
  a_reset_values: assert property (
    $fell(rst) |-> left_level == GAIN_RST && right_level == GAIN_RST
      && deemph_select == DEEMPH_OFF && word_layout_sel == LAYOUT_RJ16)
    else $error("wrong value after reset");

  c_ground: cover property ($rose(dac_sleep));
  c_amp: cover property ($rose(amp_disconnect));
  c_mute: cover property (left_level == GAIN_MUTE);
endmodule : csc_ctrl_sva

bind csc_ctrl_top csc_ctrl_sva #(.ZERO_RUN_CYCLES(ZERO_RUN_CYCLES)) u_sva (
  .core_clk(core_clk), .rst(rst), .ctl_shift_clock(ctl_shift_clock),
  .ctl_serial_in(ctl_serial_in), .ctl_latch_strobe(ctl_latch_strobe),
  .bit_clock_in(bit_clock_in), .word_clock_in(word_clock_in),
  .dac_serial_in(dac_serial_in), .adc_data_raw(adc_data_raw),
  .adc_serial_out(adc_serial_out), .left_level(left_level),
  .right_level(right_level), .adc_sleep(adc_sleep), .hpf_skip(hpf_skip),
  .dac_sleep(dac_sleep), .deemph_select(deemph_select),
  .word_layout_sel(word_layout_sel), .adc_to_dac_echo(adc_to_dac_echo),
  .left_phase(left_phase), .dac_out_mode(dac_out_mode),
  .amp_disconnect(amp_disconnect), .zero_flag_n_o(zero_flag_n_o),
  .zero_flag_n_oe(zero_flag_n_oe));

// ===== tb/csc_host_model.sv
// Host controller model driving the three-wire control port
`timescale 1ns/100ps
module csc_host_model (
  input wire logic core_clk,
  output logic ctl_shift_clock,
  output logic ctl_serial_in,
  output logic ctl_latch_strobe
);
  initial begin
    ctl_shift_clock = 1'b0;
    ctl_serial_in = 1'b0;
    ctl_latch_strobe = 1'b0;
  end

  // sole config path, MSB first, 400 ns per bit
  task automatic send(input logic [15:0] word);
    logic [15:0] w;
    w = word;
    w[15:11] = 5'h00;
    @(negedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      // Data moves with the falling shift edge, 8 core cycles per bit
      ctl_serial_in = w[i];
      repeat (4) @(negedge core_clk);
      ctl_shift_clock = 1'b1;
      repeat (4) @(negedge core_clk);
      ctl_shift_clock = 1'b0;
    end
    // Released line must not keep showing the last bit
    ctl_serial_in = ~w[0];
    repeat (2) @(negedge core_clk);
    ctl_latch_strobe = 1'b1;
    repeat (4) @(negedge core_clk);
    ctl_latch_strobe = 1'b0;
  endtask : send
endmodule : csc_host_model

// ===== tb/test_csc_ctrl_top.sv
// Self-checking bench for the codec serial control block
`timescale 1ns/100ps
module test_csc_ctrl_top;
  import csc_pkg::*;
  localparam int RUN_LEN = 16;
  logic core_clk, rst, ctl_shift_clock, ctl_serial_in, ctl_latch_strobe;
  logic bit_clock_in, word_clock_in, dac_serial_in, adc_data_raw;
  logic aud_run, raw_tog, adc_serial_out, adc_sleep, hpf_skip, dac_sleep;
  logic adc_to_dac_echo, left_phase, amp_disconnect;
  logic zero_flag_n_o, zero_flag_n_oe;
  logic [7:0] left_level, right_level;
  logic [1:0] deemph_select, word_layout_sel;
  csc_dac_mode_t dac_out_mode;
  wire zero_flag_n;
  int error_cnt = 0;
  int total_checks = 0;

  // Open-drain flag with its pull-up
  assign zero_flag_n = zero_flag_n_oe ? zero_flag_n_o : 1'b1;

  csc_ctrl_top #(.ZERO_RUN_CYCLES(RUN_LEN)) u_dut (
    .core_clk(core_clk), .rst(rst), .ctl_shift_clock(ctl_shift_clock),
    .ctl_serial_in(ctl_serial_in), .ctl_latch_strobe(ctl_latch_strobe),
    .bit_clock_in(bit_clock_in), .word_clock_in(word_clock_in),
    .dac_serial_in(dac_serial_in), .adc_data_raw(adc_data_raw),
    .adc_serial_out(adc_serial_out), .left_level(left_level),
    .right_level(right_level), .adc_sleep(adc_sleep), .hpf_skip(hpf_skip),
    .dac_sleep(dac_sleep), .deemph_select(deemph_select),
    .word_layout_sel(word_layout_sel), .adc_to_dac_echo(adc_to_dac_echo),
    .left_phase(left_phase), .dac_out_mode(dac_out_mode),
    .amp_disconnect(amp_disconnect), .zero_flag_n_o(zero_flag_n_o),
    .zero_flag_n_oe(zero_flag_n_oe));

  csc_host_model u_host (
    .core_clk(core_clk), .ctl_shift_clock(ctl_shift_clock),
    .ctl_serial_in(ctl_serial_in), .ctl_latch_strobe(ctl_latch_strobe));

  // ========
  // Clocks
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Audio clocks are offset so their edges stay clear of the core clock edges
  initial begin
    bit_clock_in = 1'b0;
    word_clock_in = 1'b1;
    #13;
    forever begin
      #200 bit_clock_in = 1'b1;
      #200 bit_clock_in = 1'b0;
      if (aud_run) word_clock_in = ~word_clock_in;
    end
  end
  always @(negedge core_clk) if (raw_tog) adc_data_raw <= ~adc_data_raw;

  // ========
  // Helpers
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] w);
    u_host.send(w);
    wait_cyc(8);
  endtask : wr
  task automatic reset_dut();
    rst = 1'b1;
    wait_cyc(6);
    rst = 1'b0;
    wait_cyc(3);
  endtask : reset_dut
  task automatic wrap_up();
    $display("TB: checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ========
  // Scenarios
  task automatic t_defaults();
    chk(left_level, GAIN_RST);
    chk(right_level, GAIN_RST);
    chk({6'h00, deemph_select}, {6'h00, DEEMPH_OFF});
    chk({6'h00, word_layout_sel}, {6'h00, LAYOUT_RJ16});
    chk({5'h00, adc_sleep, hpf_skip, dac_sleep}, 8'h00);
    chk({6'h00, dac_out_mode}, {6'h00, DAC_RUN});
  endtask : t_defaults
  task automatic t_gain();
    wr(16'h0080);
    wait_cyc(160);
    chk(left_level, GAIN_RST);
    wr(16'h02fc);
    wr(16'h01fd);
    wait_cyc(320);
    chk(left_level, 8'hfd);
    chk(right_level, 8'hfc);
  endtask : t_gain
  task automatic t_common();
    wr(16'h0422);
    wait_cyc(320);
    chk(right_level, 8'hfd);
    wr(16'h0402);
    wait_cyc(320);
    chk(right_level, 8'hfc);
  endtask : t_common
  task automatic t_mute();
    wr(16'h0403);
    wait_cyc(4500);
    chk(left_level, GAIN_MUTE);
    chk(right_level, GAIN_MUTE);
    wr(16'h0402);
    wait_cyc(4500);
    chk(left_level, 8'hfd);
  endtask : t_mute
  task automatic t_conv();
    logic [8:0] cases [5] = '{9'h100, 9'h082, 9'h044, 9'h00e, 9'h048};
    csc_dac_mode_t m;
    raw_tog = 1'b0;
    // Let the toggler's last update land before the source is pinned
    wait_cyc(1);
    adc_data_raw = 1'b1;
    foreach (cases[i]) begin
      wr({7'h02, cases[i]});
      m = cases[i][6] ? DAC_GROUND : (cases[i][3] ? DAC_MIDSCALE : DAC_RUN);
      chk({5'h00, adc_sleep, hpf_skip, dac_sleep}, {5'h00, cases[i][8:6]});
      chk({6'h00, deemph_select}, {6'h00, cases[i][2:1]});
      chk({6'h00, dac_out_mode}, {6'h00, m});
      chk({7'h00, adc_serial_out}, {7'h00, ~cases[i][8]});
    end
    wr(16'h0402);
    raw_tog = 1'b1;
  endtask : t_conv
  task automatic t_format();
    logic [1:0] lay;
    logic pol;
    logic ph;
    aud_run = 1'b0;
    for (int i = 0; i < 4; i++) begin
      lay = 2'(i);
      pol = lay[0];
      wr({7'h03, 4'h1, 1'b0, lay, pol, 1'b0});
      ph = (lay == 2'h3) ? ~word_clock_in : (word_clock_in ^ pol);
      chk({6'h00, word_layout_sel}, {6'h00, lay});
      chk({7'h00, adc_to_dac_echo}, {7'h00, lay != 2'h3});
      chk({7'h00, left_phase}, {7'h00, ph});
    end
    wr(16'h0600);
    aud_run = 1'b1;
  endtask : t_format
  task automatic t_zero();
    dac_serial_in = 1'b0;
    wait_cyc(8 * (RUN_LEN + 6));
    chk({7'h00, amp_disconnect}, 8'h00);
    chk({7'h00, zero_flag_n}, 8'h00);
    wr(16'h0412);
    chk({7'h00, amp_disconnect}, 8'h01);
    chk({6'h00, dac_out_mode}, {6'h00, DAC_MIDSCALE});
    dac_serial_in = 1'b1;
    wait_cyc(40);
    chk({7'h00, amp_disconnect}, 8'h00);
    chk({7'h00, zero_flag_n}, 8'h01);
    chk({6'h00, dac_out_mode}, {6'h00, DAC_RUN});
    wr(16'h0402);
  endtask : t_zero

  // ========
  // Main sequence
  initial begin
    rst = 1'b1;
    dac_serial_in = 1'b1;
    adc_data_raw = 1'b1;
    aud_run = 1'b1;
    raw_tog = 1'b1;
    reset_dut();
    t_defaults();
    t_gain();
    t_common();
    t_mute();
    t_conv();
    t_format();
    t_zero();
    reset_dut();
    t_defaults();
    wrap_up();
  end

  // Bounded run, about six times the expected length
  initial begin
    #4_000_000;
    error_cnt++;
    wrap_up();
  end
endmodule : test_csc_ctrl_top
